// ===== three_point_input_curve_consts.vh
// constants for the three-point analog input curve block
`ifndef THREE_POINT_INPUT_CURVE_CONSTS_VH
`define THREE_POINT_INPUT_CURVE_CONSTS_VH

// register word indexes, byte address is index times four
`define IDX_CTRL 6'h00
`define IDX_FMAX 6'h01
`define IDX_PT0 6'h02
`define IDX_PT_LAST 6'h13
`define IDX_CUR_PCT 6'h14
`define IDX_VOLT_PCT 6'h15
`define IDX_CMD 6'h16

// control register fields
`define CTRL_SEL_LSB 0
`define CTRL_SEL_MSB 1
`define CTRL_CTYPE_LSB 2
`define CTRL_CTYPE_MSB 3
`define CTRL_VTYPE_LSB 4
`define CTRL_VTYPE_MSB 5
`define CTRL_SRC_BIT 6
`define CTRL_RESET 7'h00
`define FMAX_RESET 16'h1770

// curve selection codes
`define SEL_REGULAR 2'h0
`define SEL_VOLT 2'h1
`define SEL_CUR 2'h2
`define SEL_BOTH 2'h3

// input type codes
`define CTYPE_4_20MA 2'h0
`define CTYPE_0_10V 2'h1
`define CTYPE_0_20MA 2'h2
`define VTYPE_UNIPOLAR 2'h0
`define VTYPE_BIPOLAR 2'h3

// scales in hundredths of a volt, milliamp or percent
`define FULL_PCT 16'h2710
`define SPAN_VOLT 16'h03e8
`define MID_VOLT 16'h01f4
`define SPAN_MA 16'h07d0
`define MID_MA 16'h03e8
`define LIVE_ZERO_MA 16'h0190
`define MID_LIVE_MA 16'h04b0
`define HALF_PCT 16'h1388

// point reset values: current curve, positive and negative voltage curves
`define RST_CUR_LO 16'h0190
`define RST_CUR_LO_PCT 16'h0000
`define RST_CUR_MID 16'h04b0
`define RST_CUR_MID_PCT 16'h1388
`define RST_CUR_HI 16'h07d0
`define RST_CUR_HI_PCT 16'h2710
`define RST_POS_LO 16'h0000
`define RST_POS_LO_PCT 16'h0000
`define RST_POS_MID 16'h01f4
`define RST_POS_MID_PCT 16'h1388
`define RST_POS_HI 16'h03e8
`define RST_POS_HI_PCT 16'h2710
`define RST_NEG_LO 16'h0000
`define RST_NEG_LO_PCT 16'h0000
`define RST_NEG_MID 16'h01f4
`define RST_NEG_MID_PCT 16'hec78
`define RST_NEG_HI 16'h03e8
`define RST_NEG_HI_PCT 16'hd8f0

`endif

// ===== curve_interp.v
// three-point piecewise-linear curve evaluation, combinational
`timescale 1ns/1ps
module curve_interp
(
    // input magnitude and points, hundredths of a unit
    input wire [15:0] x_i,
    input wire [15:0] p0_i,
    input wire [15:0] p1_i,
    input wire [15:0] p2_i,
    // output percentages, signed hundredths of a percent
    input wire [15:0] y0_i,
    input wire [15:0] y1_i,
    input wire [15:0] y2_i,
    // result
    output reg [15:0] y_o
);

    wire lo_seg;
    wire [15:0] xa;
    wire [15:0] xb;
    wire [15:0] ya;
    wire [15:0] yb;
    wire [16:0] dx;
    wire [16:0] span;
    wire signed [17:0] dy;
    wire signed [35:0] prod;
    wire signed [35:0] quot;
    wire signed [17:0] sum;

    // pick the segment the input lies in
    assign lo_seg = x_i < p1_i;
    assign xa = lo_seg ? p0_i : p1_i;
    assign xb = lo_seg ? p1_i : p2_i;
    assign ya = lo_seg ? y0_i : y1_i;
    assign yb = lo_seg ? y1_i : y2_i;

    // linear step between neighbouring points
    assign dx = {1'b0, x_i} - {1'b0, xa};
    assign span = {1'b0, xb} - {1'b0, xa};
    assign dy = {{2{yb[15]}}, yb} - {{2{ya[15]}}, ya};
    assign prod = $signed({{18{dy[17]}}, dy}) * $signed({19'h0, dx});
    assign quot = prod / $signed({19'h0, span});
    assign sum = {{2{ya[15]}}, ya} + quot[17:0];

    // below lowest gives zero, at or past highest holds
    always @*
    begin
        if (x_i < p0_i)
            y_o = 16'h0000;
        else if (x_i >= p2_i)
            y_o = y2_i;
        else if (span == 17'h0)
            y_o = ya;
        else
            y_o = sum[15:0];
    end

endmodule

// ===== three_point_input_curve.v
// analog input curve mapping to a frequency command, with wishbone registers
//
// Summary of operation
// - current type 1: points are 0-10 V
// - other current types: points are milliamps
// - current curve 100 % means maximum frequency
// - current output percentages unconstrained, interpolated
// - current below lowest point gives 0 %
// - positive voltage: 100 % fmax, forward
// - positive voltage below lowest gives 0 %
// - negative curve only when bipolar type
// - negative voltage: -100 % fmax, reverse
// - negative magnitude below lowest gives 0 %
// - voltage type 0 unipolar, 3 bipolar
// - selection 0 regular, 1 volt, 2 current, 3 both
//
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "three_point_input_curve_consts.vh"
module three_point_input_curve
(
    // clock, reset, clock enable
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // sampled inputs, hundredths of a volt or milliamp
    input wire sample_valid_i,
    input wire [15:0] current_analog_input_i,
    input wire [15:0] voltage_analog_input_i,
    // results
    output reg [15:0] current_pct_o,
    output reg [15:0] voltage_pct_o,
    output reg [15:0] freq_cmd_o,
    output reg reverse_o,
    output reg cmd_valid_o
);

    ////////////////////////////////////////////////////////////////////////
    // register storage

    // settings, maximum frequency and the 18 curve entries
    reg [6:0] ctrl;
    reg [15:0] fmax;
    reg [15:0] pt [0:17];

    // decode and field views
    wire [5:0] widx;
    wire bus_req;
    wire wr_en;
    wire [15:0] wmask;
    wire [15:0] wr_fmax;
    wire [1:0] curve_sel;
    wire [1:0] cur_type;
    wire [1:0] volt_type;
    wire cmd_src;

    // point reset value by entry index
    function [15:0] pt_reset;
        input integer k;
        begin
            case (k)
                0: pt_reset = `RST_CUR_LO;
                1: pt_reset = `RST_CUR_LO_PCT;
                2: pt_reset = `RST_CUR_MID;
                3: pt_reset = `RST_CUR_MID_PCT;
                4: pt_reset = `RST_CUR_HI;
                5: pt_reset = `RST_CUR_HI_PCT;
                6: pt_reset = `RST_POS_LO;
                7: pt_reset = `RST_POS_LO_PCT;
                8: pt_reset = `RST_POS_MID;
                9: pt_reset = `RST_POS_MID_PCT;
                10: pt_reset = `RST_POS_HI;
                11: pt_reset = `RST_POS_HI_PCT;
                12: pt_reset = `RST_NEG_LO;
                13: pt_reset = `RST_NEG_LO_PCT;
                14: pt_reset = `RST_NEG_MID;
                15: pt_reset = `RST_NEG_MID_PCT;
                16: pt_reset = `RST_NEG_HI;
                default: pt_reset = `RST_NEG_HI_PCT;
            endcase
        end
    endfunction

    // bus decode, a write lands on the edge that raises ack
    assign widx = wb_adr_i[7:2];
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_en = ce_i & bus_req & wb_we_i;
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // control fields
    assign curve_sel = ctrl[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
    assign cur_type = ctrl[`CTRL_CTYPE_MSB:`CTRL_CTYPE_LSB];
    assign volt_type = ctrl[`CTRL_VTYPE_MSB:`CTRL_VTYPE_LSB];
    assign cmd_src = ctrl[`CTRL_SRC_BIT];
    assign wr_fmax = (fmax & ~wmask) | (wb_dat_i[15:0] & wmask);

    // control and maximum frequency registers
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl <= `CTRL_RESET;
            fmax <= `FMAX_RESET;
        end
        else if (wr_en)
        begin
            if (widx == `IDX_CTRL)
            begin
                if (wb_sel_i[0])
                    ctrl <= wb_dat_i[6:0];
            end
            else if (widx == `IDX_FMAX)
            begin
                fmax <= wr_fmax;
            end
        end
    end

    // curve point registers, one per entry
    genvar g;
    generate
        for (g = 0; g < 18; g = g + 1)
        begin : gen_pt
            localparam [31:0] entry_num = g;
            always @(posedge clk_i)
            begin
                if (rst_i)
                    pt[g] <= pt_reset(g);
                else if (wr_en && widx == `IDX_PT0 + entry_num[5:0])
                    pt[g] <= (pt[g] & ~wmask) | (wb_dat_i[15:0] & wmask);
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // wishbone answer: one wait state, unmapped reads zero
    // ack is refused while high, so a held request is taken every other cycle
    // read data is refreshed every enabled cycle, steady while the request stands

    wire [5:0] pt_off;

    // entry offset within the point table, below 18 whenever it is used
    assign pt_off = widx - `IDX_PT0;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else if (ce_i)
        begin
            wb_ack_o <= bus_req;
            if (widx == `IDX_CTRL)
                wb_dat_o <= {25'h0, ctrl};
            else if (widx == `IDX_FMAX)
                wb_dat_o <= {16'h0000, fmax};
            else if (widx >= `IDX_PT0 && widx <= `IDX_PT_LAST)
                wb_dat_o <= {16'h0000, pt[pt_off[4:0]]};
            else if (widx == `IDX_CUR_PCT)
                wb_dat_o <= {16'h0000, current_pct_o};
            else if (widx == `IDX_VOLT_PCT)
                wb_dat_o <= {16'h0000, voltage_pct_o};
            else if (widx == `IDX_CMD)
                wb_dat_o <= {15'h0, reverse_o, freq_cmd_o};
            else
                wb_dat_o <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // current-type input curve

    reg [15:0] cur_span;
    reg [15:0] reg_p0;
    reg [15:0] reg_p1;
    wire use_cur_curve;
    wire [15:0] cur_x;
    wire [15:0] cp0;
    wire [15:0] cp1;
    wire [15:0] cp2;
    wire [15:0] cy0;
    wire [15:0] cy1;
    wire [15:0] cy2;
    wire [15:0] cur_pct;

    // unit and span follow the current type setting
    always @*
    begin
        if (cur_type == `CTYPE_0_10V)
        begin
            cur_span = `SPAN_VOLT;
            reg_p0 = 16'h0000;
            reg_p1 = `MID_VOLT;
        end
        else if (cur_type == `CTYPE_0_20MA)
        begin
            cur_span = `SPAN_MA;
            reg_p0 = 16'h0000;
            reg_p1 = `MID_MA;
        end
        else
        begin
            cur_span = `SPAN_MA;
            reg_p0 = `LIVE_ZERO_MA;
            reg_p1 = `MID_LIVE_MA;
        end
    end

    // three-point points or the regular straight line
    assign use_cur_curve = curve_sel == `SEL_CUR || curve_sel == `SEL_BOTH;
    assign cur_x = current_analog_input_i > cur_span ? cur_span : current_analog_input_i;
    assign cp0 = use_cur_curve ? pt[0] : reg_p0;
    assign cp1 = use_cur_curve ? pt[2] : reg_p1;
    assign cp2 = use_cur_curve ? pt[4] : cur_span;
    assign cy0 = use_cur_curve ? pt[1] : 16'h0000;
    assign cy1 = use_cur_curve ? pt[3] : `HALF_PCT;
    assign cy2 = use_cur_curve ? pt[5] : `FULL_PCT;

    // below lowest forced to zero, past highest held
    curve_interp u_cur_curve
    (
        .x_i(cur_x),
        .p0_i(cp0),
        .p1_i(cp1),
        .p2_i(cp2),
        .y0_i(cy0),
        .y1_i(cy1),
        .y2_i(cy2),
        .y_o(cur_pct)
    );

    ////////////////////////////////////////////////////////////////////////
    // voltage input curve, positive and negative spans

    wire use_volt_curve;
    wire bipolar;
    wire is_neg;
    wire [16:0] neg_mag_raw;
    wire [15:0] pos_x;
    wire [15:0] neg_x;
    wire [15:0] volt_x;
    wire [15:0] vp0;
    wire [15:0] vp1;
    wire [15:0] vp2;
    wire [15:0] vy0;
    wire [15:0] vy1;
    wire [15:0] vy2;
    wire [15:0] volt_curve;
    wire [15:0] volt_pct;

    // which curve applies, and the sign of the reading
    assign use_volt_curve = curve_sel == `SEL_VOLT || curve_sel == `SEL_BOTH;
    assign bipolar = volt_type == `VTYPE_BIPOLAR;
    assign is_neg = voltage_analog_input_i[15];
    assign neg_mag_raw = 17'h0 - {voltage_analog_input_i[15], voltage_analog_input_i};

    // magnitudes clamped to the 10 V span
    assign pos_x = voltage_analog_input_i > `SPAN_VOLT ? `SPAN_VOLT : voltage_analog_input_i;
    assign neg_x = neg_mag_raw > {1'b0, `SPAN_VOLT} ? `SPAN_VOLT : neg_mag_raw[15:0];
    assign volt_x = is_neg ? neg_x : pos_x;

    // negative points are magnitudes, used only in the bipolar setting
    assign vp0 = !use_volt_curve ? 16'h0000 : (is_neg ? pt[12] : pt[6]);
    assign vp1 = !use_volt_curve ? `MID_VOLT : (is_neg ? pt[14] : pt[8]);
    assign vp2 = !use_volt_curve ? `SPAN_VOLT : (is_neg ? pt[16] : pt[10]);
    assign vy0 = !use_volt_curve ? 16'h0000 : (is_neg ? pt[13] : pt[7]);
    assign vy1 = !use_volt_curve ? (is_neg ? 16'h0000 - `HALF_PCT : `HALF_PCT) :
                 (is_neg ? pt[15] : pt[9]);
    assign vy2 = !use_volt_curve ? (is_neg ? 16'h0000 - `FULL_PCT : `FULL_PCT) :
                 (is_neg ? pt[17] : pt[11]);

    // zero below lowest point of either span
    curve_interp u_volt_curve
    (
        .x_i(volt_x),
        .p0_i(vp0),
        .p1_i(vp1),
        .p2_i(vp2),
        .y0_i(vy0),
        .y1_i(vy1),
        .y2_i(vy2),
        .y_o(volt_curve)
    );

    // negative input in the unipolar setting reads as zero
    assign volt_pct = (is_neg && !bipolar) ? 16'h0000 : volt_curve;

    ////////////////////////////////////////////////////////////////////////
    // frequency command from the chosen source

    wire [15:0] cmd_pct;
    wire [15:0] cmd_mag_raw;
    wire [15:0] cmd_mag;
    wire [31:0] freq_prod;
    wire [31:0] freq_full;

    // full scale of either sign maps to the maximum frequency
    assign cmd_pct = cmd_src ? cur_pct : volt_pct;
    assign cmd_mag_raw = cmd_pct[15] ? 16'h0000 - cmd_pct : cmd_pct;
    assign cmd_mag = cmd_mag_raw > `FULL_PCT ? `FULL_PCT : cmd_mag_raw;
    // widened before the product so no bits of fmax are lost
    assign freq_prod = {16'h0000, cmd_mag} * {16'h0000, fmax};
    // truncating divide, so a full-scale command gives exactly fmax
    assign freq_full = freq_prod / {16'h0000, `FULL_PCT};

    // results registered once per sample, out the next cycle
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            current_pct_o <= 16'h0000;
            voltage_pct_o <= 16'h0000;
            freq_cmd_o <= 16'h0000;
            reverse_o <= 1'b0;
            cmd_valid_o <= 1'b0;
        end
        else if (ce_i)
        begin
            cmd_valid_o <= sample_valid_i;
            if (sample_valid_i)
            begin
                current_pct_o <= cur_pct;
                voltage_pct_o <= volt_pct;
                freq_cmd_o <= freq_full[15:0];
                reverse_o <= cmd_pct[15];
            end
        end
    end

endmodule

// ===== three_point_input_curve_assertions.sv
// assertion checker for the three-point input curve block
`timescale 1ns/1ps
module three_point_input_curve_checker
(
    // clock, reset, enable
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // sample path
    input wire sample_valid_i,
    input wire [15:0] current_pct_o,
    input wire [15:0] freq_cmd_o,
    input wire reverse_o,
    input wire cmd_valid_o
);
    // one clock domain, reset cancels every attempt
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    chk_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i && ce_i))
        else $error("ack without a request");
    chk_valid_cause: assert property (cmd_valid_o && $past(ce_i) |->
        $past(sample_valid_i))
        else $error("result strobe without a sample");
    chk_valid_next: assert property (sample_valid_i && ce_i |=> cmd_valid_o)
        else $error("sample not answered next cycle");
    chk_result_hold: assert property (!(sample_valid_i && ce_i) |=>
        $stable(current_pct_o) && $stable(freq_cmd_o))
        else $error("result moved without a sample");
    chk_ce_freeze: assert property (!ce_i |=> $stable(wb_ack_o) && $stable(cmd_valid_o))
        else $error("outputs moved with enable low");
    chk_upper_zero: assert property (wb_ack_o && wb_adr_i[7:2] != 6'h16 |->
        wb_dat_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] > 6'h16 |->
        wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    chk_cmd_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h16 &&
        $stable(freq_cmd_o) && $stable(reverse_o) |->
        wb_dat_o == {15'h0, reverse_o, freq_cmd_o})
        else $error("command readback differs from outputs");
endmodule
bind three_point_input_curve three_point_input_curve_checker i_chk (.clk_i, .rst_i, .ce_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .sample_valid_i,
    .current_pct_o, .freq_cmd_o, .reverse_o, .cmd_valid_o);

// ===== analog_sensor_model.sv
// sensor model that hands the block one reading per request
`timescale 1ns/1ps
module analog_sensor_model
(
    // clock and request
    input wire clk_i,
    input wire take_i,
    input wire [15:0] cur_level_i,
    input wire [15:0] volt_level_i,
    // sample towards the block
    output reg sample_valid_o,
    output reg [15:0] current_analog_input_o,
    output reg [15:0] voltage_analog_input_o
);
    // idle at time zero
    initial
    begin
        sample_valid_o = 1'b0;
        current_analog_input_o = 16'h0000;
        voltage_analog_input_o = 16'h0000;
    end
    // readings only mean something with the strobe, so they wander otherwise
    always @(posedge clk_i)
    begin
        sample_valid_o <= take_i;
        current_analog_input_o <= take_i ? cur_level_i : ~current_analog_input_o;
        voltage_analog_input_o <= take_i ? volt_level_i : ~voltage_analog_input_o;
    end
endmodule

// ===== three_point_input_curve_tb_top.sv
// self-checking testbench for the three-point input curve block
`timescale 1ns/1ps
module three_point_input_curve_tb_top;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg ce_i = 1'b1;
    reg wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, take = 1'b0, src = 1'b0;
    reg [7:0] wb_adr_i = 8'h00;
    reg [31:0] wb_dat_i = 32'h00000000;
    reg [15:0] lvl_c = 16'h0000, lvl_v = 16'h0000;
    wire [31:0] wb_dat_o;
    wire [15:0] cur_in, volt_in, current_pct_o, voltage_pct_o, freq_cmd_o;
    wire wb_ack_o, sample_valid, reverse_o, cmd_valid_o;
    integer err_total = 0, comparisons = 0;
    logic [15:0] rst_tab [0:19] = '{16'h0000, 16'h1770, 16'h0190, 16'h0000, 16'h04b0,
        16'h1388, 16'h07d0, 16'h2710, 16'h0000, 16'h0000, 16'h01f4, 16'h1388, 16'h03e8,
        16'h2710, 16'h0000, 16'h0000, 16'h01f4, 16'hec78, 16'h03e8, 16'hd8f0};
    logic [15:0] vexp [0:3] = '{16'h01f4, 16'h0000, 16'h01f4, 16'h0000};
    logic [15:0] cexp [0:3] = '{16'h09c4, 16'h09c4, 16'h02ee, 16'h02ee};
    // 50 MHz clock
    always #10 clk_i = ~clk_i;
    // block and sensor
    three_point_input_curve i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(4'h3), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .sample_valid_i(sample_valid), .current_analog_input_i(cur_in),
        .voltage_analog_input_i(volt_in), .current_pct_o(current_pct_o),
        .voltage_pct_o(voltage_pct_o), .freq_cmd_o(freq_cmd_o), .reverse_o(reverse_o),
        .cmd_valid_o(cmd_valid_o));
    analog_sensor_model i_sensor (.clk_i(clk_i), .take_i(take), .cur_level_i(lvl_c),
        .volt_level_i(lvl_v), .sample_valid_o(sample_valid),
        .current_analog_input_o(cur_in), .voltage_analog_input_o(volt_in));
    ////////////////////////////////////////////////////////////////
    task report_and_stop;
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bounded wait for ack (0) or result strobe (1)
    task await(input which);
        integer n;
        n = 0;
        @(posedge clk_i);
        while (((which ? cmd_valid_o : wb_ack_o) !== 1'b1) && n < 20)
        begin
            @(posedge clk_i);
            n = n + 1;
        end
        if ((which ? cmd_valid_o : wb_ack_o) !== 1'b1)
        begin
            check(1'b0, 1'b1);
            report_and_stop;
        end
    endtask
    task wb(input w, input [5:0] idx, input [15:0] d, output [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {16'h0000, d};
        await(1'b0);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task wr(input [5:0] idx, input [15:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, q);
    endtask
    task rd(input [5:0] idx, input [31:0] exp);
        logic [31:0] q;
        wb(1'b0, idx, 16'h0000, q);
        check(q, exp);
    endtask
    task ctrl(input [1:0] sel, input [1:0] ctype, input [1:0] vtype, input s);
        src = s;
        wr(6'h00, {9'h0, s, vtype, ctype, sel});
    endtask
    task smp(input [15:0] c, input [15:0] v);
        @(posedge clk_i);
        take <= 1'b1;
        lvl_c <= c;
        lvl_v <= v;
        @(posedge clk_i);
        take <= 1'b0;
        await(1'b1);
    endtask
    task run(input [15:0] c, input [15:0] v, input [15:0] ep, input [15:0] ef, input er);
        smp(c, v);
        check(src ? current_pct_o : voltage_pct_o, ep);
        check(freq_cmd_o, ef);
        check(reverse_o, er);
    endtask
    ////////////////////////////////////////////////////////////////
    task reg_reset_test;
        for (int i = 0; i < 20; i++)
            rd(i[5:0], {16'h0000, rst_tab[i]});
        wr(6'h14, 16'h1234);
        rd(6'h14, 32'h00000000);
        wr(6'h17, 16'h5a5a);
        rd(6'h17, 32'h00000000);
    endtask
    task cur_test;
        ctrl(2'h2, 2'h0, 2'h0, 1'b1);
        wr(6'h03, 16'h03e8);
        wr(6'h05, 16'h01f4);
        run(16'h018f, 16'h0000, 16'h0000, 16'h0000, 1'b0);
        run(16'h0190, 16'h0000, 16'h03e8, 16'h0258, 1'b0);
        run(16'h0320, 16'h0000, 16'h02ee, 16'h01c2, 1'b0);
        run(16'h0640, 16'h0000, 16'h1482, 16'h0c4e, 1'b0);
        run(16'h07d0, 16'h0000, 16'h2710, 16'h1770, 1'b0);
        ctrl(2'h2, 2'h2, 2'h0, 1'b1);
        run(16'h05dc, 16'h0000, 16'h0fde, 16'h0985, 1'b0);
        ctrl(2'h2, 2'h1, 2'h0, 1'b1);
        run(16'h05dc, 16'h0000, 16'h0271, 16'h0177, 1'b0);
    endtask
    task volt_test;
        ctrl(2'h1, 2'h0, 2'h3, 1'b0);
        wr(6'h08, 16'h0064);
        wr(6'h09, 16'h03e8);
        wr(6'h0e, 16'h00c8);
        wr(6'h0f, 16'hf830);
        run(16'h0000, 16'h0032, 16'h0000, 16'h0000, 1'b0);
        run(16'h0000, 16'h0064, 16'h03e8, 16'h0258, 1'b0);
        run(16'h0000, 16'h012c, 16'h0bb8, 16'h0708, 1'b0);
        run(16'h0000, 16'h03e8, 16'h2710, 16'h1770, 1'b0);
        run(16'h0000, 16'hff9c, 16'h0000, 16'h0000, 1'b0);
        run(16'h0000, 16'hff38, 16'hf830, 16'h04b0, 1'b1);
        run(16'h0000, 16'hfea2, 16'hf254, 16'h0834, 1'b1);
        run(16'h0000, 16'hfc18, 16'hd8f0, 16'h1770, 1'b1);
        rd(6'h16, 32'h00011770);
        ctrl(2'h1, 2'h0, 2'h0, 1'b0);
        run(16'h0000, 16'hfe0c, 16'h0000, 16'h0000, 1'b0);
    endtask
    task sel_test;
        for (int s = 0; s < 4; s++)
        begin
            ctrl(s[1:0], 2'h0, 2'h3, 1'b1);
            smp(16'h0320, 16'h0032);
            check(voltage_pct_o, vexp[s]);
            check(current_pct_o, cexp[s]);
        end
    endtask
    task ce_test;
        @(posedge clk_i);
        ce_i <= 1'b0;
        take <= 1'b1;
        @(posedge clk_i);
        take <= 1'b0;
        repeat (2) @(posedge clk_i);
        check(cmd_valid_o, 1'b0);
        ce_i <= 1'b1;
        @(posedge clk_i);
        check(cmd_valid_o, 1'b0);
    endtask
    // reset, then the scenarios
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        reg_reset_test;
        cur_test;
        volt_test;
        sel_test;
        ce_test;
        report_and_stop;
    end
endmodule
